/* File: pd_vendor_pkg.sv */
// Shared constants, types and encodings for the vendor sink transmit, swap and alert block.
package pd_vendor_pkg;
   // Register offsets.
   localparam logic [7:0] OFS_SINK_TX = 8'hB0;
   localparam logic [7:0] OFS_SRC_SWAP = 8'hB1;
   localparam logic [7:0] OFS_SNK_SWAP = 8'hB2;
   localparam logic [7:0] OFS_ALERT = 8'hB3;
   localparam logic [7:0] OFS_ALERT_MASK = 8'hB4;
   // Reset values.
   localparam logic [7:0] RST_SINK_TX = 8'h40;
   localparam logic [7:0] RST_SRC_SWAP = 8'h00;
   localparam logic [7:0] RST_SNK_SWAP = 8'h00;
   localparam logic [6:0] RST_ALERT = 7'h00;
   localparam logic [6:0] RST_ALERT_MASK = 7'h7F;
   // Writable bits of the sink transmit and source swap registers; the rest read as zero except the swap start bit.
   localparam logic [7:0] WMASK_SINK_TX = 8'h77;
   localparam logic [7:0] WMASK_SRC_SWAP = 8'h0E;
   // Sink transmit field positions.
   localparam int SINK_TX_DISABLE_BIT = 6;
   localparam int RETRANSMIT_LSB = 4;
   localparam int FRAME_SEL_LSB = 0;
   // Source and sink swap field positions.
   localparam int GATE_DELAY_LSB = 2;
   localparam int MANUAL_SINK_BIT = 1;
   localparam int SWAP_START_BIT = 0;
   localparam int SWAP_DETECT_BIT = 0;
   // Alert bit positions.
   localparam int ALERT_DISCHARGE_BIT = 6;
   localparam int ALERT_INPUT2_BIT = 5;
   localparam int ALERT_INPUT1_BIT = 4;
   localparam int ALERT_SUPPLY_BIT = 3;
   localparam int ALERT_OTP_BIT = 2;
   localparam int ALERT_SWAP_TX_BIT = 1;
   localparam int ALERT_SWAP_RX_BIT = 0;
   // Frame select codes that carry no retries.
   localparam logic [2:0] FRAME_HARD_RESET = 3'h5;
   localparam logic [2:0] FRAME_CABLE_RESET = 3'h6;
   localparam logic [2:0] FRAME_BIST_MODE2 = 3'h7;
   // Advertised Rp current level from the CC status logic.
   localparam logic [1:0] RP_LEVEL_1A5 = 2'h2;
   localparam logic [1:0] RP_LEVEL_3A0 = 2'h3;
   // Sink gate delay codes and times.
   localparam logic [1:0] GATE_DELAY_NONE = 2'h0;
   localparam logic [1:0] GATE_DELAY_150 = 2'h1;
   localparam logic [1:0] GATE_DELAY_300 = 2'h2;
   localparam int CLK_FREQ_MHZ = 20;
   localparam int GATE_DLY_150_US = 150;
   localparam int GATE_DLY_300_US = 300;
   localparam int GATE_DLY_600_US = 600;
   localparam int GATE_DLY_150_CYC = GATE_DLY_150_US * CLK_FREQ_MHZ;
   localparam int GATE_DLY_300_CYC = GATE_DLY_300_US * CLK_FREQ_MHZ;
   localparam int GATE_DLY_600_CYC = GATE_DLY_600_US * CLK_FREQ_MHZ;
   localparam int DLY_CNT_W = 16;

   typedef enum logic [3:0] {
      STX_IDLE = 4'b0001,
      STX_ARMED = 4'b0010,
      STX_SEND = 4'b0100,
      STX_WAIT = 4'b1000
   } stx_state_t;

   typedef struct packed {
      logic [7:0] addr;
      logic wr;
      logic rd;
      logic [7:0] wdata;
   } reg_req_t;

   typedef struct packed {
      logic valid;
      logic [2:0] frame;
   } tx_cmd_t;
endpackage

/* File: gate_delay_timer.sv */
// Delay timer that turns the sink gate on a programmed time after swap signalling ends.
`timescale 1ns/100ps
module gate_delay_timer import pd_vendor_pkg::*; #(
   parameter int unsigned DLY_150_CYC = GATE_DLY_150_CYC,
   parameter int unsigned DLY_300_CYC = GATE_DLY_300_CYC,
   parameter int unsigned DLY_600_CYC = GATE_DLY_600_CYC
) (
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic reset_n_in,
   // Control
   input wire logic start_in,
   input wire logic [1:0] code_in,
   input wire logic cancel_in,
   // Result
   output logic done_out
);
   typedef struct packed {
      logic busy;
      logic [DLY_CNT_W-1:0] cnt;
      logic done;
   } tmr_state_t;

   tmr_state_t st_ff;
   tmr_state_t nxt_st;

   // Refuse at elaboration a zero count, or a DLY_600_CYC count too large for the down-counter.
   if (DLY_150_CYC < 1 || DLY_300_CYC < 1 || DLY_600_CYC < 1 ||
       DLY_600_CYC >= (1 << DLY_CNT_W)) begin : g_bad_delay
      $error("gate_delay_timer: delay counts out of range");
   end

   function automatic logic [DLY_CNT_W-1:0] load_count(input logic [1:0] code);
      case (code)
         GATE_DELAY_150: load_count = DLY_CNT_W'(DLY_150_CYC - 1);
         GATE_DELAY_300: load_count = DLY_CNT_W'(DLY_300_CYC - 1);
         default: load_count = DLY_CNT_W'(DLY_600_CYC - 1);
      endcase
   endfunction

   always_comb begin
      nxt_st = st_ff;
      nxt_st.done = 1'b0;
      if (cancel_in) begin
         nxt_st.busy = 1'b0;
      end else if (start_in) begin
         nxt_st.busy = 1'b1;
         nxt_st.cnt = load_count(code_in);
      end else if (st_ff.busy) begin
         if (st_ff.cnt == '0) begin
            nxt_st.busy = 1'b0;
            nxt_st.done = 1'b1;
         end else begin
            nxt_st.cnt = st_ff.cnt - 1'b1;
         end
      end
   end

   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign done_out = st_ff.done;
endmodule // gate_delay_timer

/* File: pd_vendor_sink_tx_frs_alerts.sv */
// Vendor sink transmit, fast role swap control and vendor alert registers.
`timescale 1ns/100ps
module pd_vendor_sink_tx_frs_alerts import pd_vendor_pkg::*; #(
   parameter int unsigned DLY_150_CYC = GATE_DLY_150_CYC,
   parameter int unsigned DLY_300_CYC = GATE_DLY_300_CYC,
   parameter int unsigned DLY_600_CYC = GATE_DLY_600_CYC
) (
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic reset_n_in,
   // Register port from the management interface
   input wire reg_req_t reg_req_in,
   output logic [7:0] reg_rdata_out,
   // Port role and CC status
   input wire logic is_source_in,
   input wire logic [1:0] cc_rp_level_in,
   // PD transmitter
   output tx_cmd_t tx_cmd_out,
   input wire logic tx_done_in,
   input wire logic tx_ok_in,
   // Fast role swap signalling
   output logic frs_signal_req_out,
   input wire logic frs_signal_done_in,
   input wire logic frs_rx_detect_in,
   input wire logic input2_swap_function_in,
   input wire logic gpo2_enable_in,
   // Sink gate
   output logic sink_gate_on_out,
   input wire logic sink_gate_off_in,
   // Alert sources
   input wire logic gpi1_pin_in,
   input wire logic gpi2_pin_in,
   input wire logic supply_detect_pin_in,
   input wire logic discharge_done_in,
   input wire logic otp_event_in,
   // Status and interrupt
   output logic supply_present_out,
   output logic irq_out
);
   typedef struct packed {
      logic [7:0] sink_tx;
      logic [7:0] src_swap;
      logic swap_detect_en;
      logic [6:0] alert;
      logic [6:0] alert_mask;
      logic [7:0] rdata;
      stx_state_t stx;
      logic [1:0] retries_left;
      logic tx_valid;
      logic [2:0] tx_frame;
      logic [1:0] rp_prev;
      logic frs_busy;
      logic frs_from_input;
      logic frs_req;
      logic gate_on;
      logic timer_start;
      logic [2:0] pin_s1;
      logic [2:0] pin_s2;
      logic [2:0] pin_prev;
   } blk_state_t;

   blk_state_t st_ff;
   blk_state_t nxt_st;
   logic timer_done;

   function automatic logic wr_hit(input reg_req_t req, input logic [7:0] ofs);
      wr_hit = req.wr && (req.addr == ofs);
   endfunction

   function automatic logic [1:0] retry_budget(input logic [7:0] stx_reg);
      logic [2:0] frame;
      frame = stx_reg[FRAME_SEL_LSB +: 3];
      if (frame == FRAME_HARD_RESET || frame == FRAME_CABLE_RESET ||
          frame == FRAME_BIST_MODE2) begin
         retry_budget = 2'h0;
      end else begin
         retry_budget = stx_reg[RETRANSMIT_LSB +: 2];
      end
   endfunction

   gate_delay_timer #(
      .DLY_150_CYC(DLY_150_CYC),
      .DLY_300_CYC(DLY_300_CYC),
      .DLY_600_CYC(DLY_600_CYC)
   ) u_gate_delay (
      .ref_clk_in(ref_clk_in),
      .reset_n_in(reset_n_in),
      .start_in(st_ff.timer_start),
      .code_in(st_ff.src_swap[GATE_DELAY_LSB +: 2]),
      .cancel_in(sink_gate_off_in),
      .done_out(timer_done)
   );

   always_comb begin
      logic [6:0] set_bits;
      logic [6:0] clr_bits;
      logic in2_fall;
      logic rp_step;
      set_bits = '0;
      clr_bits = '0;
      in2_fall = 1'b0;
      rp_step = 1'b0;
      nxt_st = st_ff;
      nxt_st.frs_req = 1'b0;
      nxt_st.tx_valid = 1'b0;
      nxt_st.timer_start = 1'b0;

      // Pins pass two flops; edges are taken only from the second stage onward.
      nxt_st.pin_s1 = {supply_detect_pin_in, gpi2_pin_in, gpi1_pin_in};
      nxt_st.pin_s2 = st_ff.pin_s1;
      nxt_st.pin_prev = st_ff.pin_s2;
      nxt_st.rp_prev = cc_rp_level_in;

      // Register reads answer one cycle later; unmapped offsets read zero.
      nxt_st.rdata = 8'h00;
      if (reg_req_in.rd) begin
         case (reg_req_in.addr)
            OFS_SINK_TX: nxt_st.rdata = st_ff.sink_tx;
            OFS_SRC_SWAP: nxt_st.rdata = st_ff.src_swap;
            OFS_SNK_SWAP: nxt_st.rdata = {7'h00, st_ff.swap_detect_en};
            OFS_ALERT: nxt_st.rdata = {1'b0, st_ff.alert};
            OFS_ALERT_MASK: nxt_st.rdata = {1'b0, st_ff.alert_mask};
            default: nxt_st.rdata = 8'h00;
         endcase
      end

      // Sink transmit register and its arming.
      if (wr_hit(reg_req_in, OFS_SINK_TX)) begin
         nxt_st.sink_tx = reg_req_in.wdata & WMASK_SINK_TX;
         // A write while source, or with the feature disabled, stores but never arms.
         if (!is_source_in && !reg_req_in.wdata[SINK_TX_DISABLE_BIT]) begin
            nxt_st.stx = STX_ARMED;
         end else begin
            nxt_st.stx = STX_IDLE;
         end
      end else begin
         rp_step = (st_ff.rp_prev == RP_LEVEL_1A5) && (cc_rp_level_in == RP_LEVEL_3A0);
         case (st_ff.stx)
            STX_IDLE: nxt_st.stx = STX_IDLE;
            STX_ARMED: begin
               if (st_ff.sink_tx[SINK_TX_DISABLE_BIT] || is_source_in) begin
                  nxt_st.stx = STX_IDLE;
               end else if (rp_step) begin
                  nxt_st.stx = STX_SEND;
                  nxt_st.retries_left = retry_budget(st_ff.sink_tx);
               end
            end
            STX_SEND: begin
               nxt_st.tx_valid = 1'b1;
               nxt_st.tx_frame = st_ff.sink_tx[FRAME_SEL_LSB +: 3];
               nxt_st.stx = STX_WAIT;
            end
            STX_WAIT: begin
               if (tx_done_in) begin
                  if (!tx_ok_in && st_ff.retries_left != 2'h0) begin
                     nxt_st.retries_left = st_ff.retries_left - 1'b1;
                     nxt_st.stx = STX_SEND;
                  end else begin
                     nxt_st.stx = STX_IDLE;
                  end
               end
            end
            default: nxt_st.stx = STX_IDLE;
         endcase
      end

      // Source swap control; the start bit is only set by hardware on a write of 1.
      if (wr_hit(reg_req_in, OFS_SRC_SWAP)) begin
         nxt_st.src_swap[3:1] = reg_req_in.wdata[3:1] & WMASK_SRC_SWAP[3:1];
      end
      in2_fall = st_ff.pin_prev[1] && !st_ff.pin_s2[1];
      if (!st_ff.frs_busy) begin
         if (wr_hit(reg_req_in, OFS_SRC_SWAP) && reg_req_in.wdata[SWAP_START_BIT]) begin
            nxt_st.src_swap[SWAP_START_BIT] = 1'b1;
            nxt_st.frs_busy = 1'b1;
            nxt_st.frs_from_input = 1'b0;
            nxt_st.frs_req = 1'b1;
            if (!reg_req_in.wdata[MANUAL_SINK_BIT] &&
                reg_req_in.wdata[GATE_DELAY_LSB +: 2] == GATE_DELAY_NONE) begin
               nxt_st.gate_on = 1'b1;
            end
         end else if (in2_fall && input2_swap_function_in && !gpo2_enable_in) begin
            nxt_st.frs_busy = 1'b1;
            nxt_st.frs_from_input = 1'b1;
            nxt_st.frs_req = 1'b1;
         end
      end else if (frs_signal_done_in) begin
         nxt_st.frs_busy = 1'b0;
         nxt_st.src_swap[SWAP_START_BIT] = 1'b0;
         if (st_ff.frs_from_input) begin
            set_bits[ALERT_SWAP_TX_BIT] = 1'b1;
         end else if (!st_ff.src_swap[MANUAL_SINK_BIT] &&
                      st_ff.src_swap[GATE_DELAY_LSB +: 2] != GATE_DELAY_NONE) begin
            nxt_st.timer_start = 1'b1;
         end
      end
      if (timer_done) begin
         nxt_st.gate_on = 1'b1;
      end
      if (sink_gate_off_in) begin
         nxt_st.gate_on = 1'b0;
      end

      // Sink swap detection; a fresh arming write wins over a detect in the same cycle.
      if (st_ff.swap_detect_en && frs_rx_detect_in) begin
         nxt_st.swap_detect_en = 1'b0;
         set_bits[ALERT_SWAP_RX_BIT] = 1'b1;
      end
      if (wr_hit(reg_req_in, OFS_SNK_SWAP)) begin
         nxt_st.swap_detect_en = reg_req_in.wdata[SWAP_DETECT_BIT];
      end

      // Alert event sources.
      set_bits[ALERT_DISCHARGE_BIT] = discharge_done_in;
      set_bits[ALERT_INPUT2_BIT] = st_ff.pin_prev[1] ^ st_ff.pin_s2[1];
      set_bits[ALERT_INPUT1_BIT] = st_ff.pin_prev[0] ^ st_ff.pin_s2[0];
      set_bits[ALERT_SUPPLY_BIT] = st_ff.pin_prev[2] ^ st_ff.pin_s2[2];
      set_bits[ALERT_OTP_BIT] = otp_event_in;

      // Write one to clear; an event in the clearing cycle keeps its flag set.
      if (wr_hit(reg_req_in, OFS_ALERT)) begin
         clr_bits = reg_req_in.wdata[6:0];
      end
      nxt_st.alert = (st_ff.alert & ~clr_bits) | set_bits;

      if (wr_hit(reg_req_in, OFS_ALERT_MASK)) begin
         nxt_st.alert_mask = reg_req_in.wdata[6:0];
      end
   end

   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         st_ff <= '0;
         st_ff.sink_tx <= RST_SINK_TX;
         st_ff.src_swap <= RST_SRC_SWAP;
         st_ff.swap_detect_en <= RST_SNK_SWAP[SWAP_DETECT_BIT];
         st_ff.alert <= RST_ALERT;
         st_ff.alert_mask <= RST_ALERT_MASK;
         st_ff.stx <= STX_IDLE;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign reg_rdata_out = st_ff.rdata;
   assign tx_cmd_out = '{valid: st_ff.tx_valid, frame: st_ff.tx_frame};
   assign frs_signal_req_out = st_ff.frs_req;
   assign sink_gate_on_out = st_ff.gate_on;
   // The supply level is the synchronised pin, kept for the vendor status register.
   assign supply_present_out = st_ff.pin_s2[2];
   assign irq_out = |(st_ff.alert & st_ff.alert_mask);
endmodule // pd_vendor_sink_tx_frs_alerts

/* File: pd_vendor_checker_assertions.sv */
// Port-level assertions for the vendor sink transmit, swap and alert block.
`timescale 1ns/100ps
module pd_vendor_checker import pd_vendor_pkg::*; #(
   parameter int unsigned DLY_150_CYC = GATE_DLY_150_CYC
) (
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic reset_n_in,
   // Register port
   input wire reg_req_t reg_req_in,
   input wire logic [7:0] reg_rdata_out,
   // Role, CC and transmitter
   input wire logic is_source_in,
   input wire logic [1:0] cc_rp_level_in,
   input wire tx_cmd_t tx_cmd_out,
   input wire logic tx_done_in,
   input wire logic tx_ok_in,
   // Swap and gate
   input wire logic frs_signal_req_out,
   input wire logic frs_signal_done_in,
   input wire logic frs_rx_detect_in,
   input wire logic input2_swap_function_in,
   input wire logic gpo2_enable_in,
   input wire logic sink_gate_on_out,
   input wire logic sink_gate_off_in,
   // Alerts and status
   input wire logic gpi1_pin_in,
   input wire logic gpi2_pin_in,
   input wire logic supply_detect_pin_in,
   input wire logic discharge_done_in,
   input wire logic otp_event_in,
   input wire logic supply_present_out,
   input wire logic irq_out
);
   localparam int D_LO = DLY_150_CYC - 1;
   localparam int D_HI = DLY_150_CYC + 4;
   typedef struct packed {
      logic [1:0] code;
      logic manual;
      logic arm;
      logic [6:0] mask;
   } shadow_t;
   shadow_t sh_ff, nxt_sh;
   // Shadow of the writable controls, so assertions can see what software asked for.
   always_comb begin
      nxt_sh = sh_ff;
      if (reg_req_in.wr && reg_req_in.addr == OFS_SRC_SWAP) begin
         nxt_sh.code = reg_req_in.wdata[3:2];
         nxt_sh.manual = reg_req_in.wdata[1];
      end
      if (frs_rx_detect_in)
         nxt_sh.arm = 1'b0;
      if (reg_req_in.wr && reg_req_in.addr == OFS_SNK_SWAP)
         nxt_sh.arm = reg_req_in.wdata[0];
      if (reg_req_in.wr && reg_req_in.addr == OFS_ALERT_MASK)
         nxt_sh.mask = reg_req_in.wdata[6:0];
   end
   always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
      if (!reset_n_in)
         sh_ff <= {2'h0, 1'b0, 1'b0, RST_ALERT_MASK};
      else
         sh_ff <= nxt_sh;
   end
   default clocking cb @(posedge ref_clk_in);
   endclocking
   default disable iff (!reset_n_in);
   chk_tx_cause:
      assert property (tx_cmd_out.valid |-> $past(cc_rp_level_in, 2) == RP_LEVEL_3A0
         && $past(cc_rp_level_in, 3) == RP_LEVEL_1A5 || $past(tx_done_in && !tx_ok_in, 2))
         else $error("tx request without cause");
   chk_tx_pulse:
      assert property (tx_cmd_out.valid |=> !tx_cmd_out.valid) else $error("tx pulse long");
   chk_no_retry:
      assert property (tx_done_in && !tx_ok_in && tx_cmd_out.frame >= FRAME_HARD_RESET
         |-> ##2 !tx_cmd_out.valid) else $error("reset frame retried");
   chk_req_pulse:
      assert property (frs_signal_req_out |=> !frs_signal_req_out) else $error("swap req long");
   chk_gate_now:
      assert property ($rose(frs_signal_req_out) && $past(reg_req_in.wr)
         && $past(reg_req_in.addr) == OFS_SRC_SWAP && $past(reg_req_in.wdata[3:0]) == 4'h1
         |-> sink_gate_on_out) else $error("gate late for code 0");
   chk_gate_delay:
      assert property (frs_signal_done_in && sh_ff.code == GATE_DELAY_150 && !sh_ff.manual
         |-> ##[D_LO:D_HI] sink_gate_on_out) else $error("gate delay wrong");
   chk_gate_manual:
      assert property (sh_ff.manual |-> !$rose(sink_gate_on_out)) else $error("gate in manual");
   chk_irq_rx:
      assert property (frs_rx_detect_in && sh_ff.arm && sh_ff.mask[0] |=> irq_out)
         else $error("no irq on swap detect");
   chk_irq_masked:
      assert property (sh_ff.mask == 7'h00 |-> !irq_out) else $error("irq while masked");
   chk_irq_event:
      assert property (otp_event_in && sh_ff.mask[2] || discharge_done_in && sh_ff.mask[6]
         |=> irq_out) else $error("no irq on event");
   cover property (tx_cmd_out.valid);
   cover property (frs_signal_req_out);
   cover property ($rose(sink_gate_on_out));
endmodule // pd_vendor_checker
bind pd_vendor_sink_tx_frs_alerts pd_vendor_checker #(.DLY_150_CYC(DLY_150_CYC))
   pd_vendor_checker_i (.*);

/* File: pm_model.sv */
// Port manager model that issues register requests on the management port.
`timescale 1ns/100ps
module pm_model import pd_vendor_pkg::*; (
   // Clock and role
   input wire logic ref_clk_in,
   input wire logic is_source_in,
   // Register port
   input wire logic [7:0] rdata_in,
   output reg_req_t req_out
);
   initial req_out = '0;
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk_in);
      if (is_source_in && a == OFS_SINK_TX)
         return;
      #2;
      req_out = '{addr:a, wr:1'b1, rd:1'b0, wdata:d};
      @(posedge ref_clk_in);
      #2;
      req_out = '{addr:~a, wr:1'b0, rd:1'b0, wdata:~d};
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge ref_clk_in);
      #2;
      req_out = '{addr:a, wr:1'b0, rd:1'b1, wdata:8'h00};
      @(posedge ref_clk_in);
      #2;
      req_out = '{addr:~a, wr:1'b0, rd:1'b0, wdata:8'hFF};
      d = rdata_in;
   endtask
endmodule // pm_model

/* File: pd_vendor_sink_tx_frs_alerts_tb_top.sv */
// Self-checking bench for the vendor sink transmit, swap and alert block.
`timescale 1ns/100ps
module pd_vendor_sink_tx_frs_alerts_tb_top import pd_vendor_pkg::*;;
   localparam int D150 = 5;
   logic ref_clk, reset_n = 1'b0;
   reg_req_t req;
   tx_cmd_t tx;
   logic [7:0] rdata, d, dat;
   logic src = 1'b0, done = 1'b0, ok = 1'b0, fdone = 1'b0, frx = 1'b0, fn2 = 1'b0;
   logic g2en = 1'b0, goff = 1'b0, g1 = 1'b0, g2 = 1'b0, sup = 1'b0, dis = 1'b0, otp = 1'b0;
   logic freq, gate, sp, irq, hit;
   logic [1:0] rp = 2'h0;
   logic [31:0] seed = 32'h10;
   logic [7:0] mdl [5];
   int error_cnt = 0, num_checks = 0, n, t, ex;
   int dl[4] = '{0, D150, 2 * D150, 4 * D150};
   pd_vendor_sink_tx_frs_alerts #(.DLY_150_CYC(D150), .DLY_300_CYC(2 * D150),
      .DLY_600_CYC(4 * D150)) pd_vendor_sink_tx_frs_alerts_i (
      .ref_clk_in(ref_clk), .reset_n_in(reset_n), .reg_req_in(req), .reg_rdata_out(rdata),
      .is_source_in(src), .cc_rp_level_in(rp), .tx_cmd_out(tx), .tx_done_in(done),
      .tx_ok_in(ok), .frs_signal_req_out(freq), .frs_signal_done_in(fdone),
      .frs_rx_detect_in(frx), .input2_swap_function_in(fn2), .gpo2_enable_in(g2en),
      .sink_gate_on_out(gate), .sink_gate_off_in(goff), .gpi1_pin_in(g1), .gpi2_pin_in(g2),
      .supply_detect_pin_in(sup), .discharge_done_in(dis), .otp_event_in(otp),
      .supply_present_out(sp), .irq_out(irq));
   pm_model pm_model_i (.ref_clk_in(ref_clk), .is_source_in(src), .rdata_in(rdata),
      .req_out(req));
   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end
   function automatic logic [31:0] xs(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction
   task automatic cyc(input int k);
      repeat (k) @(posedge ref_clk);
      #2;
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic cmp_reg(input int i);
      logic [7:0] v;
      pm_model_i.rd(OFS_SINK_TX + 8'(i), v);
      chk(v, mdl[i]);
   endtask
   task automatic report_and_stop;
      if (error_cnt == 0 && num_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (6000) @(posedge ref_clk);
      error_cnt++;
      report_and_stop();
   end
   initial begin
      mdl = '{8'h40, 8'h00, 8'h00, 8'h00, 8'h7F};
      cyc(2);
      reset_n = 1'b1;
      for (int i = 0; i < 5; i++)
         cmp_reg(i);
      pm_model_i.rd(8'hB5, d);
      chk(d, 8'h00);
      // The five pin and event alert sources fire at once while all alerts are unmasked.
      {g1, g2, sup, otp, dis} = 5'h1F;
      cyc(1);
      {otp, dis} = 2'h0;
      cyc(4);
      mdl[3] = 8'h7C;
      chk({7'h0, sp}, 8'h01);
      chk({7'h0, irq}, 8'h01);
      cmp_reg(3);
      pm_model_i.wr(OFS_ALERT, 8'h00);
      cmp_reg(3);
      pm_model_i.wr(OFS_ALERT_MASK, 8'h00);
      chk({7'h0, irq}, 8'h00);
      seed = xs(seed);
      pm_model_i.wr(OFS_ALERT_MASK, seed[7:0]);
      mdl[4] = seed[7:0] & 8'h7F;
      cmp_reg(4);
      chk({7'h0, irq}, {7'h0, |(mdl[3] & mdl[4])});
      pm_model_i.wr(OFS_ALERT, 8'hFF);
      mdl[3] = 8'h00;
      cmp_reg(3);
      // The last pass arms as a sink and then turns source before the Rp step.
      for (int i = 0; i < 10; i++) begin
         dat = (i < 8) ? {2'h0, 2'(i), 1'b0, 3'(i)} : (i == 8) ? 8'h40 : 8'h00;
         ok = (i == 3);
         ex = (i >= 8) ? 0 : (i >= 5 || i == 3) ? 1 : i % 4 + 1;
         pm_model_i.wr(OFS_SINK_TX, dat);
         src = (i == 9);
         mdl[0] = dat;
         rp = RP_LEVEL_3A0;
         cyc(3);
         rp = RP_LEVEL_1A5;
         cyc(1);
         rp = RP_LEVEL_3A0;
         n = 0;
         t = 0;
         while (t < 8) begin
            cyc(1);
            t++;
            if (tx.valid === 1'b1) begin
               n++;
               chk({5'h0, tx.frame}, dat & 8'h07);
               cyc(2);
               done = 1'b1;
               cyc(1);
               done = 1'b0;
               t = 0;
            end
         end
         chk(8'(n), 8'(ex));
         rp = 2'h0;
         src = 1'b0;
         cmp_reg(0);
      end
      for (int i = 0; i < 5; i++) begin
         dat = {4'h0, 2'(i), i == 4, 1'b1};
         pm_model_i.wr(OFS_SRC_SWAP, dat);
         chk({6'h0, freq, gate}, {6'h0, 1'b1, i == 0});
         mdl[1] = dat;
         cmp_reg(1);
         fdone = 1'b1;
         cyc(1);
         fdone = 1'b0;
         t = 0;
         while (gate !== 1'b1 && t < 40) begin
            cyc(1);
            t++;
         end
         hit = (i == 4) ? (t == 40) : (t + 1 >= dl[i % 4] && t <= dl[i % 4] + 4);
         chk({7'h0, hit}, 8'h01);
         mdl[1] = dat & 8'h0E;
         cmp_reg(1);
         goff = 1'b1;
         cyc(1);
         goff = 1'b0;
      end
      pm_model_i.wr(OFS_SRC_SWAP, 8'h02);
      chk({7'h0, freq}, 8'h00);
      pm_model_i.wr(OFS_ALERT_MASK, 8'h7F);
      mdl[4] = 8'h7F;
      pm_model_i.wr(OFS_SNK_SWAP, 8'h01);
      mdl[2] = 8'h01;
      cmp_reg(2);
      frx = 1'b1;
      cyc(1);
      frx = 1'b0;
      cyc(1);
      mdl[2] = 8'h00;
      mdl[3] = 8'h01;
      cmp_reg(2);
      cmp_reg(3);
      chk({7'h0, irq}, 8'h01);
      // Falling input 2 with the swap function on and the output driver off.
      fn2 = 1'b1;
      g2 = 1'b0;
      t = 0;
      while (freq !== 1'b1 && t < 8) begin
         cyc(1);
         t++;
      end
      chk({7'h0, freq}, 8'h01);
      fdone = 1'b1;
      cyc(1);
      fdone = 1'b0;
      cyc(1);
      mdl[3] = 8'h23;
      cmp_reg(3);
      pm_model_i.wr(OFS_ALERT, 8'hFF);
      mdl[3] = 8'h00;
      cmp_reg(3);
      chk({7'h0, irq}, 8'h00);
      // A reset in mid-run must bring every register back to its default.
      {g1, sup, fn2} = 3'h0;
      reset_n = 1'b0;
      cyc(1);
      reset_n = 1'b1;
      mdl = '{8'h40, 8'h00, 8'h00, 8'h00, 8'h7F};
      chk({7'h0, irq}, 8'h00);
      for (int i = 0; i < 5; i++)
         cmp_reg(i);
      report_and_stop();
   end
endmodule // pd_vendor_sink_tx_frs_alerts_tb_top
